// file: pkg/timer_two_compare_regs.vh
// register map, field positions and reset values of the two-compare timer
//
// Summary of operation
// - counter and both compare value registers are eight bits wide
// - two compare units, A and B, each compare against the shared counter
// - three interrupt sources: overflow, match A and match B
// - every pending request is readable in the timer flag register
// - each request is gated by its own timer mask register bit
// - tick comes from the prescaled internal clock or the external input
// - clock select picks source and, for the external input, its edge
// - three-bit clock select field in timer control B picks the tick
// - counter neither counts nor clears while no clock is selected
// - both compare values are checked against the counter on every tick except the first tick after a counter write
// - a compare match sets that unit's match flag
// - match results drive the waveform generator and the wave outputs
// - in the pwm modes compare values are double buffered behind a software buffer
// - clear-on-match mode reloads the counter to zero on match A
// - glitch-free phase correct PWM mode is supported
// - counter is at its floor when it becomes 0x00
// - counter is at its ceiling when it becomes 0xFF
// - top is either 0xFF or compare value A, chosen by mode
// - a counter write wins over any clear or count in that cycle
// - a match sets its flag one timer tick after the match
// - a match flag clears on interrupt acknowledge or a written one
// - a counter write suppresses matches during the next tick
`ifndef TIMER_TWO_COMPARE_REGS_VH
`define TIMER_TWO_COMPARE_REGS_VH

// byte offsets on the register bus
`define OFS_TIMER_CONTROL_A 8'h00
`define OFS_TIMER_CONTROL_B 8'h04
`define OFS_TIMER_COUNT 8'h08
`define OFS_COMPARE_VALUE_A 8'h0C
`define OFS_COMPARE_VALUE_B 8'h10
`define OFS_TIMER_MASK 8'h14
`define OFS_TIMER_FLAG 8'h18

// timer control a fields
`define CTLA_MODE_LO 1:0
`define CTLA_OUT_B 5:4
`define CTLA_OUT_A 7:6
// timer control b fields
`define CTLB_CLOCK_SELECT 2:0
`define CTLB_MODE_HI 3
`define CTLB_FORCE_B 6
`define CTLB_FORCE_A 7

// flag and mask bit positions
`define FLAG_OVERFLOW 0
`define FLAG_MATCH_A 1
`define FLAG_MATCH_B 2

// waveform modes
`define MODE_NORMAL 3'h0
`define MODE_PHASE_FF 3'h1
`define MODE_CLEAR_ON_MATCH 3'h2
`define MODE_FAST_FF 3'h3
`define MODE_PHASE_A 3'h5
`define MODE_FAST_A 3'h7

// counter limits and reset values
`define COUNT_BOTTOM 8'h00
`define COUNT_MAX 8'hFF
`define RESET_BYTE 8'h00
`define PRESCALE_WIDTH 10

`endif

// file: logic/eight_bit_timer_two_compare.v
// eight-bit timer with two compare units behind an axi4-lite slave
`timescale 1ns/10ps
`include "timer_two_compare_regs.vh"

module eight_bit_timer_two_compare #(
	parameter ADDR_WIDTH = 8
) (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire [ADDR_WIDTH-1:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	input wire [ADDR_WIDTH-1:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	input wire externalCountInput,
	input wire ackOverflow,
	input wire ackMatchA,
	input wire ackMatchB,
	output reg irqOverflow,
	output reg irqMatchA,
	output reg irqMatchB,
	output reg waveOutA,
	output reg waveOutB
);

	// address decode shared by read and write: {valid, index}
	function [3:0] decodeReg;
		input [ADDR_WIDTH-1:0] a;
		begin
			case (a[7:0])
				`OFS_TIMER_CONTROL_A: decodeReg = 4'h8;
				`OFS_TIMER_CONTROL_B: decodeReg = 4'h9;
				`OFS_TIMER_COUNT: decodeReg = 4'hA;
				`OFS_COMPARE_VALUE_A: decodeReg = 4'hB;
				`OFS_COMPARE_VALUE_B: decodeReg = 4'hC;
				`OFS_TIMER_MASK: decodeReg = 4'hD;
				`OFS_TIMER_FLAG: decodeReg = 4'hE;
				default: decodeReg = 4'h0;
			endcase
		end
	endfunction

	// output action on match: 0 none, 1 toggle, 2 clear, 3 set
	function [1:0] matchAction;
		input [1:0] com;
		input isUnitA;
		input [2:0] mode;
		input up;
		begin
			matchAction = 2'h0;
			case (mode)
				`MODE_FAST_FF, `MODE_FAST_A: begin
					if (com[1])
						matchAction = com;
					else if (com == 2'h1 && isUnitA && mode == `MODE_FAST_A)
						matchAction = 2'h1;
				end
				`MODE_PHASE_FF, `MODE_PHASE_A: begin
					if (com[1])
						matchAction = (com[0] ^ up) ? 2'h2 : 2'h3;
					else if (com == 2'h1 && isUnitA && mode == `MODE_PHASE_A)
						matchAction = 2'h1;
				end
				default: matchAction = com;
			endcase
		end
	endfunction

	// applies an action code to the current output level
	function applyAction;
		input cur;
		input [1:0] act;
		begin
			case (act)
				2'h1: applyAction = ~cur;
				2'h2: applyAction = 1'b0;
				2'h3: applyAction = 1'b1;
				default: applyAction = cur;
			endcase
		end
	endfunction

	reg [7:0] timerControlA;
	reg [2:0] clockSelectField;
	reg modeHigh;
	reg [7:0] timerCount;
	reg [7:0] compareValueA;
	reg [7:0] compareValueB;
	reg [7:0] bufferA;
	reg [7:0] bufferB;
	reg [2:0] timerMaskRegister;
	reg [2:0] timerFlagRegister;
	reg countUp;
	reg blockNext;
	reg extPrev;
	reg [`PRESCALE_WIDTH-1:0] prescale;
	reg awHeld;
	reg wHeld;
	reg [ADDR_WIDTH-1:0] wrAddr;
	reg [31:0] wrData;
	reg [3:0] wrStrb;

	reg timerTick;
	reg [31:0] next_rdata;
	reg [7:0] next_count;
	reg next_up;
	reg next_overflow;
	reg reachTop;
	reg updateCompare;

	wire [2:0] mode = {modeHigh, timerControlA[`CTLA_MODE_LO]};
	wire fastPwm = (mode == `MODE_FAST_FF) || (mode == `MODE_FAST_A);
	wire phasePwm = (mode == `MODE_PHASE_FF) || (mode == `MODE_PHASE_A);
	wire anyPwm = fastPwm || phasePwm;
	wire topIsA = (mode == `MODE_CLEAR_ON_MATCH) ||
		(mode == `MODE_PHASE_A) || (mode == `MODE_FAST_A);
	wire [7:0] topValue = topIsA ? compareValueA : `COUNT_MAX;
	wire atBottom = (timerCount == `COUNT_BOTTOM);
	wire atMax = (timerCount == `COUNT_MAX);
	wire atTop = (timerCount == topValue);

	// bus handshake terms
	wire awTake = awvalid && awready;
	wire wTake = wvalid && wready;
	wire arTake = arvalid && arready;
	wire doWrite = awHeld && wHeld && !bvalid;
	wire [3:0] wrSel = decodeReg(wrAddr);
	wire [3:0] rdSel = decodeReg(araddr);
	wire wrLow = doWrite && wrStrb[0];
	wire wrCount = wrLow && wrSel == 4'hA;
	wire wrCtlB = wrLow && wrSel == 4'h9;
	wire next_awHeld = (awHeld && !doWrite) || awTake;
	wire next_wHeld = (wHeld && !doWrite) || wTake;
	wire next_bvalid = (bvalid && !bready) || doWrite;
	wire next_rvalid = (rvalid && !rready) || arTake;

	// both units compare on every tick unless a counter write blocks it
	wire matchA = timerTick && !blockNext &&
		timerCount == compareValueA;
	wire matchB = timerTick && !blockNext &&
		timerCount == compareValueB;
	wire forceA = wrCtlB && wrData[`CTLB_FORCE_A] && !anyPwm;
	wire forceB = wrCtlB && wrData[`CTLB_FORCE_B] && !anyPwm;

	// clock select: prescaled internal clock or chosen external edge
	always @* begin
		case (clockSelectField)
			3'h1: timerTick = 1'b1;
			3'h2: timerTick = &prescale[2:0];
			3'h3: timerTick = &prescale[5:0];
			3'h4: timerTick = &prescale[7:0];
			3'h5: timerTick = &prescale;
			3'h6: timerTick = extPrev && !externalCountInput; // falling
			3'h7: timerTick = !extPrev && externalCountInput; // rising
			default: timerTick = 1'b0; // stopped
		endcase
	end

	// next counter value for the selected sequence
	always @* begin
		next_count = timerCount + 8'h01;
		next_up = countUp;
		next_overflow = 1'b0;
		reachTop = 1'b0;
		updateCompare = !anyPwm;
		if (phasePwm) begin
			if (countUp && atTop) begin
				next_count = timerCount - 8'h01;
				next_up = 1'b0;
				updateCompare = 1'b1;
			end else if (!countUp && atBottom) begin
				next_count = timerCount + 8'h01;
				next_up = 1'b1;
				next_overflow = 1'b1;
			end else if (!countUp) begin
				next_count = timerCount - 8'h01;
			end
		end else if (fastPwm) begin
			next_up = 1'b1;
			if (atTop) begin
				next_count = `COUNT_BOTTOM;
				next_overflow = 1'b1;
				reachTop = 1'b1;
				updateCompare = 1'b1;
			end
		end else if (mode == `MODE_CLEAR_ON_MATCH) begin
			next_up = 1'b1;
			next_overflow = atMax;
			if (atTop)
				next_count = `COUNT_BOTTOM;
		end else begin
			next_up = 1'b1;
			next_overflow = atMax; // wrap to zero
		end
	end

	// read data mux
	always @* begin
		case (rdSel)
			4'h8: next_rdata = {24'h000000, timerControlA};
			4'h9: next_rdata = {28'h0000000, modeHigh, clockSelectField};
			4'hA: next_rdata = {24'h000000, timerCount};
			4'hB: next_rdata = {24'h000000, bufferA};
			4'hC: next_rdata = {24'h000000, bufferB};
			4'hD: next_rdata = {29'h00000000, timerMaskRegister};
			4'hE: next_rdata = {29'h00000000, timerFlagRegister};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// axi4-lite slave channels
	always @(posedge clk) begin
		if (reset) begin
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			rvalid <= 1'b0;
			rresp <= 2'h0;
			rdata <= 32'h00000000;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wrAddr <= {ADDR_WIDTH{1'b0}};
			wrData <= 32'h00000000;
			wrStrb <= 4'h0;
		end else if (ce) begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			bvalid <= next_bvalid;
			rvalid <= next_rvalid;
			awready <= !next_awHeld && !next_bvalid;
			wready <= !next_wHeld && !next_bvalid;
			arready <= !next_rvalid;
			if (awTake)
				wrAddr <= awaddr;
			if (wTake) begin
				wrData <= wdata;
				wrStrb <= wstrb;
			end
			if (doWrite)
				bresp <= wrSel[3] ? 2'h0 : 2'h2; // slverr when unmapped
			if (arTake) begin
				rdata <= next_rdata;
				rresp <= rdSel[3] ? 2'h0 : 2'h2;
			end
		end
	end

	// control, mask and compare registers
	always @(posedge clk) begin
		if (reset) begin
			timerControlA <= `RESET_BYTE;
			clockSelectField <= 3'h0;
			modeHigh <= 1'b0;
			timerMaskRegister <= 3'h0;
			bufferA <= `RESET_BYTE;
			bufferB <= `RESET_BYTE;
			compareValueA <= `RESET_BYTE;
			compareValueB <= `RESET_BYTE;
		end else if (ce) begin
			if (wrLow && wrSel == 4'h8)
				timerControlA <= wrData[7:0];
			if (wrCtlB) begin
				clockSelectField <= wrData[`CTLB_CLOCK_SELECT];
				modeHigh <= wrData[`CTLB_MODE_HI];
			end
			if (wrLow && wrSel == 4'hD)
				timerMaskRegister <= wrData[2:0];
			// software writes land in the buffer first
			if (wrLow && wrSel == 4'hB)
				bufferA <= wrData[7:0];
			if (wrLow && wrSel == 4'hC)
				bufferB <= wrData[7:0];
			// non-pwm copies at once, pwm only on the tick at top
			if (updateCompare && (!anyPwm || timerTick)) begin
				compareValueA <= bufferA;
				compareValueB <= bufferB;
			end
		end
	end

	// counter, direction and match blocking
	always @(posedge clk) begin
		if (reset) begin
			timerCount <= `RESET_BYTE;
			countUp <= 1'b1;
			blockNext <= 1'b0;
			extPrev <= 1'b0;
			prescale <= {`PRESCALE_WIDTH{1'b0}};
		end else if (ce) begin
			extPrev <= externalCountInput;
			prescale <= prescale + {{(`PRESCALE_WIDTH-1){1'b0}}, 1'b1};
			if (wrCount) begin
				timerCount <= wrData[7:0]; // write wins
				blockNext <= 1'b1; // even while stopped
			end else if (timerTick) begin
				timerCount <= next_count; // only on a tick
				countUp <= next_up;
				blockNext <= 1'b0;
			end
		end
	end

	// sticky flags: a set in the same cycle beats any clear
	always @(posedge clk) begin
		if (reset) begin
			timerFlagRegister <= 3'h0;
		end else if (ce) begin
			timerFlagRegister[`FLAG_OVERFLOW] <=
				(timerTick && next_overflow && !wrCount) ||
				(timerFlagRegister[`FLAG_OVERFLOW] && !ackOverflow &&
				!(wrLow && wrSel == 4'hE && wrData[`FLAG_OVERFLOW]));
			timerFlagRegister[`FLAG_MATCH_A] <= matchA ||
				(timerFlagRegister[`FLAG_MATCH_A] && !ackMatchA &&
				!(wrLow && wrSel == 4'hE &&
				wrData[`FLAG_MATCH_A]));
			timerFlagRegister[`FLAG_MATCH_B] <= matchB ||
				(timerFlagRegister[`FLAG_MATCH_B] && !ackMatchB &&
				!(wrLow && wrSel == 4'hE &&
				wrData[`FLAG_MATCH_B]));
		end
	end

	// masked interrupt requests, one per source
	always @(posedge clk) begin
		if (reset) begin
			irqOverflow <= 1'b0;
			irqMatchA <= 1'b0;
			irqMatchB <= 1'b0;
		end else if (ce) begin
			irqOverflow <= timerFlagRegister[`FLAG_OVERFLOW] &&
				timerMaskRegister[`FLAG_OVERFLOW];
			irqMatchA <= timerFlagRegister[`FLAG_MATCH_A] &&
				timerMaskRegister[`FLAG_MATCH_A];
			irqMatchB <= timerFlagRegister[`FLAG_MATCH_B] &&
				timerMaskRegister[`FLAG_MATCH_B];
		end
	end

	// waveform generator: bottom action in fast pwm, then match action
	always @(posedge clk) begin
		if (reset) begin
			waveOutA <= 1'b0;
			waveOutB <= 1'b0;
		end else if (ce) begin
			if (matchA || forceA)
				waveOutA <= applyAction(waveOutA, matchAction(
					timerControlA[`CTLA_OUT_A], 1'b1, mode, countUp));
			else if (timerTick && reachTop && !wrCount &&
				timerControlA[7])
				waveOutA <= ~timerControlA[6];
			if (matchB || forceB)
				waveOutB <= applyAction(waveOutB, matchAction(
					timerControlA[`CTLA_OUT_B], 1'b0, mode, countUp));
			else if (timerTick && reachTop && !wrCount &&
				timerControlA[5])
				waveOutB <= ~timerControlA[4];
		end
	end

endmodule // eight_bit_timer_two_compare

// file: test/timer_two_compare_properties.sv
// port-level checks for the two-compare timer
`timescale 1ns/10ps
module timer_two_compare_properties (
	input wire clk,
	input wire reset,
	input wire ce,
	input wire awready,
	input wire wready,
	input wire [1:0] bresp,
	input wire bvalid,
	input wire bready,
	input wire arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire [1:0] rresp,
	input wire rvalid,
	input wire rready,
	input wire ackOverflow,
	input wire ackMatchA,
	input wire irqOverflow,
	input wire irqMatchA,
	input wire irqMatchB,
	input wire waveOutA,
	input wire waveOutB
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// bus handshake and hold
	a_read_answer: assert property (arvalid && arready && ce |=> rvalid)
		else $error("no read answer after address taken");
	a_read_holds: assert property (rvalid && !rready |=>
		rvalid && $stable(rdata))
		else $error("read data dropped before taken");
	a_write_holds: assert property (bvalid && !bready |=>
		bvalid && $stable(bresp))
		else $error("write response dropped before taken");
	a_ar_blocked: assert property (rvalid |-> !arready)
		else $error("read address accepted while answer pending");
	a_aw_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	a_resp_legal: assert property (bvalid |-> !bresp[0])
		else $error("illegal write response code");
	// reset, freeze and flag clearing
	a_reset_clears: assert property (disable iff (1'b0) reset && ce |=>
		!bvalid && !rvalid && !irqOverflow && !irqMatchA && !irqMatchB
		&& !waveOutA && !waveOutB)
		else $error("outputs not cleared by reset");
	a_ce_freeze: assert property (!ce |=> $stable(rvalid) && $stable(bvalid)
		&& $stable(waveOutA) && $stable(irqMatchB))
		else $error("state moved while clock enable low");
	a_ack_clears_a: assert property (
		ackMatchA && ce ##1 ce |=> !irqMatchA)
		else $error("match a request survived acknowledge");
	a_ack_clears_ovf: assert property (
		ackOverflow && ce ##1 ce |=> !irqOverflow)
		else $error("overflow request survived acknowledge");
	cover property (bvalid && bready);
	cover property (rvalid && rready);
	cover property ($changed(waveOutA));
endmodule // timer_two_compare_properties

// file: test/tb.sv
// self-checking bench for the two-compare timer
`timescale 1ns/10ps
`include "timer_two_compare_regs.vh"
module tb;
	localparam [7:0] CTLA = `OFS_TIMER_CONTROL_A;
	localparam [7:0] CTLB = `OFS_TIMER_CONTROL_B;
	localparam [7:0] CNT = `OFS_TIMER_COUNT;
	localparam [7:0] CMPA = `OFS_COMPARE_VALUE_A;
	localparam [7:0] CMPB = `OFS_COMPARE_VALUE_B;
	localparam [7:0] MSK = `OFS_TIMER_MASK;
	localparam [7:0] FLG = `OFS_TIMER_FLAG;
	logic clk = 0, reset = 1, ce = 1, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, externalCountInput = 0;
	logic ackOverflow = 0, ackMatchA = 0, ackMatchB = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	wire awready, wready, bvalid, arready, rvalid;
	wire irqOverflow, irqMatchA, irqMatchB, waveOutA, waveOutB;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int err_count = 0, total_checks = 0;
	logic [1:0] rs;
	logic [31:0] rd;
	int ha, hb;

	eight_bit_timer_two_compare eight_bit_timer_two_compare_i (.clk, .reset,
		.ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .externalCountInput, .ackOverflow,
		.ackMatchA, .ackMatchB, .irqOverflow, .irqMatchA, .irqMatchB,
		.waveOutA, .waveOutB);

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// compare and report
	task chk(input [31:0] g, input [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// axi4-lite write, response code left in rs
	task wr(input [7:0] a, input [31:0] d);
		bit da, dw;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1;
		wvalid <= 1;
		da = 0;
		dw = 0;
		while (!(da && dw)) begin
			@(negedge clk);
			da = da | (awready === 1'b1);
			dw = dw | (wready === 1'b1);
			@(posedge clk);
			if (da) awvalid <= 0;
			if (dw) wvalid <= 0;
		end
		bready <= 1;
		do @(negedge clk); while (bvalid !== 1'b1);
		rs = bresp;
		@(posedge clk);
		bready <= 0;
	endtask

	// axi4-lite read into rd and rs
	task rdr(input [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 0;
		rready <= 1;
		do @(negedge clk); while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		@(posedge clk);
		rready <= 0;
	endtask

	task rchk(input [7:0] a, input [31:0] e);
		rdr(a);
		chk(rd, e);
	endtask

	// count high samples of both wave outputs over n cycles
	task hi_count(input int n);
		ha = 0;
		hb = 0;
		repeat (n) begin
			@(negedge clk);
			if (waveOutA === 1'b1) ha++;
			if (waveOutB === 1'b1) hb++;
		end
	endtask

	// one pulse on the external count input
	task pulse;
		@(posedge clk);
		externalCountInput <= 1;
		cyc(3);
		externalCountInput <= 0;
		cyc(3);
	endtask

	task t_reset;
		for (int i = 0; i < 7; i++) rchk(4 * i, 0);
		$display("reset values done");
	endtask

	task t_bus;
		wr(CMPA, 32'hFFFFFFA5);
		rchk(CMPA, 32'hA5);
		wr(8'h1C, 32'h1);
		chk(rs, 2'h2); // unmapped write refused
		rchk(8'h1C, 0);
		chk(rs, 2'h2); // unmapped read refused
		$display("bus done");
	endtask

	task t_stopped;
		wr(CNT, 8'h37);
		@(posedge clk);
		ce <= 0;
		cyc(4);
		ce <= 1;
		cyc(16);
		rchk(CNT, 8'h37);
		$display("stopped done");
	endtask

	task t_overflow;
		wr(CNT, 8'hF0);
		wr(MSK, 1);
		wr(CTLB, 1);
		cyc(30);
		wr(CTLB, 0);
		rchk(FLG, 5);
		chk({irqOverflow, irqMatchB}, 2'b10);
		@(posedge clk);
		ackOverflow <= 1;
		@(posedge clk);
		ackOverflow <= 0;
		cyc(2);
		chk(irqOverflow, 0);
		wr(FLG, 4);
		rchk(FLG, 0);
		$display("overflow done");
	endtask

	task t_match;
		wr(CMPA, 8'h20);
		wr(CMPB, 8'h30);
		wr(MSK, 6);
		wr(CNT, 0);
		wr(CTLB, 1);
		cyc(100);
		wr(CTLB, 0);
		rchk(FLG, 6);
		chk({irqMatchA, irqMatchB}, 2'b11);
		@(posedge clk);
		ackMatchA <= 1;
		@(posedge clk);
		ackMatchA <= 0;
		ackMatchB <= 1;
		@(posedge clk);
		ackMatchB <= 0;
		rchk(FLG, 0);
		$display("match done");
	endtask

	task t_block;
		wr(CMPA, 8'h40);
		wr(CNT, 8'h40);
		wr(CTLB, 1);
		cyc(10);
		wr(CTLB, 0);
		rchk(FLG, 0);
		$display("block done");
	endtask

	task t_ctc;
		int t;
		logic p;
		wr(CTLA, 8'h42);
		wr(CMPA, 8'h05);
		wr(CNT, 0);
		wr(CTLB, 1);
		t = 0;
		p = waveOutA;
		repeat (60) begin
			@(negedge clk);
			if (waveOutA !== p) t++;
			p = waveOutA;
		end
		wr(CTLB, 0);
		rdr(CNT);
		chk(rd <= 5, 1);
		chk(t > 0, 1);
		rchk(FLG, 2);
		wr(CTLA, 0);
		wr(FLG, 7);
		$display("clear on match done");
	endtask

	task t_ext;
		for (int s = 6; s < 8; s++) begin
			wr(CNT, 0);
			wr(CTLB, s);
			repeat (10) pulse;
			wr(CTLB, 0);
			rchk(CNT, 10);
		end
		$display("external clock done");
	endtask

	// flag follows the match by one tick, stepped by hand
	task t_lag;
		wr(FLG, 7);
		wr(CMPA, 8'h05);
		wr(CNT, 8'h04);
		wr(CTLB, 7);
		pulse;
		rchk(CNT, 5);
		rchk(FLG, 0);
		pulse;
		rchk(FLG, 2);
		wr(CTLB, 0);
		wr(FLG, 7);
		$display("match lag done");
	endtask

	// force strobes move output b without a flag
	task t_force;
		wr(CTLA, 8'h30);
		wr(CTLB, 8'h40);
		@(negedge clk);
		chk(waveOutB, 1);
		wr(CTLA, 8'h20);
		wr(CTLB, 8'h40);
		@(negedge clk);
		chk(waveOutB, 0);
		rchk(CTLB, 0);
		rchk(FLG, 0);
		$display("force done");
	endtask

	// fast pwm, top 0xFF: a non-inverted, b inverted
	task t_fast;
		wr(CMPA, 8'h40);
		wr(CMPB, 8'h30);
		wr(CNT, 0);
		wr(CTLA, 8'hB3);
		wr(CTLB, 1);
		cyc(300);
		hi_count(256);
		wr(CTLB, 0);
		chk(ha, 65);
		chk(hb, 207);
		rchk(FLG, 7);
		wr(FLG, 7);
		$display("fast pwm done");
	endtask

	// phase correct pwm, period 510 ticks, symmetric pulse
	task t_phase;
		wr(CNT, 0);
		wr(CTLA, 8'h81);
		wr(CTLB, 1);
		cyc(600);
		hi_count(510);
		wr(CTLB, 0);
		chk(ha, 128);
		rchk(FLG, 7);
		wr(CTLA, 0);
		$display("phase pwm done");
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		t_reset;
		t_bus;
		t_stopped;
		t_overflow;
		t_match;
		t_block;
		t_ctc;
		t_ext;
		t_lag;
		t_force;
		t_fast;
		t_phase;
		wrap_up;
	end

	// watchdog
	initial begin
		#100000;
		err_count++;
		wrap_up;
	end
endmodule // tb

bind eight_bit_timer_two_compare timer_two_compare_properties
	timer_two_compare_properties_i (.clk, .reset, .ce, .awready, .wready,
	.bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid,
	.rready, .ackOverflow, .ackMatchA, .irqOverflow, .irqMatchA,
	.irqMatchB, .waveOutA, .waveOutB);
